// File: core/mfe_defs.svh
// Timing, size and layout constants of the multichannel FIR engine
`ifndef MFE_DEFS_SVH
`define MFE_DEFS_SVH
`define MFE_CLK_NS 8
`define MFE_POINT_NS 50
`define MFE_MAC_CYC (`MFE_POINT_NS / `MFE_CLK_NS)
`define MFE_ADD_CYC (`MFE_MAC_CYC / 2)
`define MFE_NCHAN 16
`define MFE_CH_W 4
`define MFE_MAX_POINTS 128
`define MFE_MAX_PAIRS (`MFE_MAX_POINTS / 2)
`define MFE_NSETS 32
`define MFE_SET_W 5
`define MFE_BUF_DEPTH 2048
`define MFE_BUF_AW 11
`define MFE_PTR_W 7
`define MFE_COEF_AW 11
`define MFE_BP_OUTS 20
`define MFE_BP_MAX_PAIRS 16
`define MFE_ACC_W 40
`define MFE_OUT_LSB 15
`endif

// File: core/mfe_pkg.sv
// Types shared by the FIR engine modules
package mfe_pkg;
  typedef enum logic {MFE_LOWPASS, MFE_BANDPASS} mfe_mode_t;
  typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_DRAIN} mfe_state_t;
  typedef logic signed [15:0] mfe_sample_t;
  typedef logic signed [16:0] mfe_pair_t;
endpackage

// File: core/mfe_add_if.sv
// Carrier between the controller and the byte-wide pair adder
`timescale 1ns/1ps
`default_nettype none
interface mfe_add_if;
  logic [7:0] a_byte; // Byte of newer sample
  logic [7:0] b_byte; // Byte of older sample
  logic en_lo; // Low-byte adder cycle
  logic en_hi; // High-byte adder cycle
  logic signed [16:0] sum; // Completed pair sum
  modport ctl (output a_byte, output b_byte, output en_lo, output en_hi, input sum);
  modport add (input a_byte, input b_byte, input en_lo, input en_hi, output sum);
endinterface
`default_nettype wire

// File: core/mfe_pair_adder.sv
// Byte-wide adder that builds a 17-bit pair sum in two cycles
`timescale 1ns/1ps
`default_nettype none
module mfe_pair_adder (
  input wire logic clk, // Core clock
  input wire logic resetn, // Async reset, active low
  mfe_add_if.add bus // Operand and sum carrier
);
  logic [8:0] hold_q; // Low byte of sum and its carry
  logic signed [16:0] sum_q; // Full pair sum
  logic [8:0] hi_sum; // Sign-extended high-byte sum

  // High half uses the carry kept from the low half
  always_comb
  begin
    hi_sum = {bus.a_byte[7], bus.a_byte} + {bus.b_byte[7], bus.b_byte} + {8'h00, hold_q[8]};
  end

  // Low half first, carry captured for the next adder cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      hold_q <= 9'h000;
    else if (bus.en_lo)
      hold_q <= {1'b0, bus.a_byte} + {1'b0, bus.b_byte};
  end

  // High half second; sum stands for one multiplier cycle
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sum_q <= 17'h00000;
    else if (bus.en_hi)
      sum_q <= {hi_sum, hold_q[7:0]};
  end

  assign bus.sum = sum_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_lo_then_hi;
    bus.en_lo ##3 bus.en_hi;
  endsequence

  a_carry_hold: assert property (bus.en_lo |=>
    hold_q == ({1'b0, $past(bus.a_byte)} + {1'b0, $past(bus.b_byte)}))
    else $error("low byte or carry not held");
  a_pair_chain: assert property (s_lo_then_hi |=>
    sum_q[7:0] == hold_q[7:0] && sum_q[16:8] == $past(hi_sum))
    else $error("pair sum not chained from low half");
endmodule
`default_nettype wire

// File: core/mfe_engine.sv
// Time-multiplexed symmetric FIR engine for sixteen channels
`timescale 1ns/1ps
`default_nettype none
`include "mfe_defs.svh"
module mfe_engine
  import mfe_pkg::*;
(
  input wire logic clk, // Core clock, 125 MHz
  input wire logic resetn, // Async reset, active low
  input wire mfe_mode_t mode, // Low-pass or band-pass bank
  input wire logic in_we, // Strobe of a new input sample
  input wire logic [3:0] in_chan, // Channel of the input sample
  input wire logic [15:0] in_data, // Input sample
  input wire logic cfg_we, // Strobe of a channel setup
  input wire logic [3:0] cfg_chan, // Channel being set up
  input wire logic [4:0] cfg_set, // Coefficient set for the channel
  input wire logic [6:0] cfg_pairs, // Symmetric pairs, zero idles it
  input wire logic cfg_fb, // Take input from another output
  input wire logic [3:0] cfg_src, // Channel whose output feeds in
  input wire logic coef_we, // Strobe of a coefficient word
  input wire logic [10:0] coef_addr, // Set and pair index
  input wire logic [15:0] coef_data, // Fractional coefficient
  output logic out_valid, // One-cycle output pulse
  output logic [3:0] out_chan, // Channel of the output
  output logic [15:0] out_data // Filtered output
);
  // Pair count used by the sequencer; band-pass bank is clamped
  function automatic logic [6:0] eff_pairs(input mfe_mode_t m, input logic [6:0] p);
    if (m == MFE_BANDPASS && p > 7'(`MFE_BP_MAX_PAIRS))
      return 7'(`MFE_BP_MAX_PAIRS);
    return p;
  endfunction

  mfe_add_if add_bus ();

  logic [2:0] tick_q; // Clock count inside a multiplier cycle
  logic add_lo; // Adder cycle for low bytes
  logic mac_en; // Multiplier cycle, also high-byte adder cycle
  logic [7:0] buf_lo [0:`MFE_BUF_DEPTH-1]; // Low byte bank
  logic [7:0] buf_hi [0:`MFE_BUF_DEPTH-1]; // High byte bank
  logic [7:0] cs_lo [0:`MFE_BUF_DEPTH-1]; // Coefficient low bytes
  logic [7:0] cs_hi [0:`MFE_BUF_DEPTH-1]; // Coefficient high bytes
  logic [4:0] set_q [0:`MFE_NCHAN-1]; // Set per channel
  logic [6:0] pairs_q [0:`MFE_NCHAN-1]; // Pairs per channel
  logic fb_q [0:`MFE_NCHAN-1]; // Feedback select per channel
  logic [3:0] src_q [0:`MFE_NCHAN-1]; // Feedback source per channel
  logic [15:0] in_q [0:`MFE_NCHAN-1]; // Latest input per channel
  logic [15:0] last_q [0:`MFE_NCHAN-1]; // Latest output per channel
  logic [6:0] wptr_q [0:`MFE_NCHAN-1]; // Write pointer per region
  mfe_state_t st_q; // Sequencer state
  logic [3:0] ch_q; // Channel in service
  logic [5:0] kk_q; // Pair index of the issued point
  logic drain_q; // Second drain cycle
  logic [4:0] outs_q; // Outputs since last band-pass write
  logic [3:0] bch; // Buffer region read and written
  logic [6:0] np; // Effective pairs of this channel
  logic act; // Channel has work
  logic wr_go; // Sample write this cycle
  logic iss; // A pair is issued this cycle
  logic [10:0] ra_new; // Newer sample address
  logic [10:0] ra_old; // Older sample address
  logic [15:0] wr_data; // Sample to be written
  logic [2:0] vld_q; // Pipe valid: sum, mac input, spare
  logic [1:0] first_q; // First flag along the pipe
  logic [1:0] last_q_p; // Last flag along the pipe
  logic [10:0] ca_d0_q; // Coefficient address, first delay
  logic [10:0] ca_d1_q; // Coefficient address, store register
  logic signed [15:0] coef; // Coefficient read from the store
  logic signed [16:0] x_q; // Pair sum at the multiplier input
  logic signed [32:0] prod; // Product of pair and coefficient
  logic signed [`MFE_ACC_W-1:0] acc_q; // Accumulator with guard bits
  logic signed [`MFE_ACC_W-1:0] acc_d; // Next accumulator value
  logic out_valid_q; // Output strobe register
  logic [3:0] out_chan_q; // Output channel register
  logic [15:0] out_data_q; // Output data register

  // Divider: adder enable every third clock, multiplier every sixth
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tick_q <= 3'h0;
    else if (mac_en)
      tick_q <= 3'h0;
    else
      tick_q <= tick_q + 3'h1;
  end
  assign add_lo = (tick_q == 3'(`MFE_ADD_CYC - 1));
  assign mac_en = (tick_q == 3'(`MFE_MAC_CYC - 1));

  // Per-channel input holding registers and setup table
  for (genvar c = 0; c < `MFE_NCHAN; c++)
  begin : g_chan
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
        in_q[c] <= 16'h0000;
      else if (in_we && in_chan == 4'(c))
        in_q[c] <= in_data;
    end
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        set_q[c] <= 5'h00;
        pairs_q[c] <= 7'h00;
        fb_q[c] <= 1'b0;
        src_q[c] <= 4'h0;
      end
      else if (cfg_we && cfg_chan == 4'(c))
      begin
        set_q[c] <= cfg_set;
        pairs_q[c] <= (cfg_pairs > 7'(`MFE_MAX_PAIRS)) ? 7'(`MFE_MAX_PAIRS) : cfg_pairs;
        fb_q[c] <= cfg_fb;
        src_q[c] <= cfg_src;
      end
    end
  end

  // Band-pass bank shares region 0 as its single input stream
  always_comb
  begin
    bch = (mode == MFE_BANDPASS) ? 4'h0 : ch_q;
    np = eff_pairs(mode, pairs_q[ch_q]);
    act = (np != 7'h00);
    wr_go = (st_q == ST_LOAD) && act && (mode == MFE_LOWPASS || outs_q == 5'h00);
    iss = (st_q == ST_RUN);
    wr_data = fb_q[ch_q] ? last_q[src_q[ch_q]] : in_q[ch_q];
    ra_new = {bch, 7'(wptr_q[bch] - 7'h01 - {1'b0, kk_q})};
    ra_old = {bch, 7'(wptr_q[bch] - 7'({np, 1'b0}) + {1'b0, kk_q})};
  end

  // Sample banks; one byte lane each, written at most once per pass
  // Cleared at reset so that early passes filter silence, never unknown words
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `MFE_BUF_DEPTH; i++)
      begin
        buf_lo[i] <= 8'h00;
        buf_hi[i] <= 8'h00;
      end
    end
    else if (mac_en && wr_go)
    begin
      buf_lo[{bch, wptr_q[bch]}] <= wr_data[7:0];
      buf_hi[{bch, wptr_q[bch]}] <= wr_data[15:8];
    end
  end

  // Write pointers advance only with a sample write
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `MFE_NCHAN; i++)
        wptr_q[i] <= 7'h00;
    end
    else if (mac_en && wr_go)
      wptr_q[bch] <= wptr_q[bch] + 7'h01;
  end

  // Coefficient store, loaded by the outside as two byte lanes
  always_ff @(posedge clk)
  begin
    if (coef_we)
    begin
      cs_lo[coef_addr] <= coef_data[7:0];
      cs_hi[coef_addr] <= coef_data[15:8];
    end
  end

  // Sequencer: load a sample, issue pairs, drain the pipe, next channel
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= ST_LOAD;
      ch_q <= 4'h0;
      kk_q <= 6'h00;
      drain_q <= 1'b0;
    end
    else if (mac_en)
    begin
      unique case (st_q)
        ST_LOAD:
        begin
          kk_q <= 6'h00;
          if (act)
            st_q <= ST_RUN;
          else
            ch_q <= ch_q + 4'h1;
        end
        ST_RUN:
        begin
          kk_q <= kk_q + 6'h01;
          // Also ends a pass whose pair count shrank while it ran
          if (7'({1'b0, kk_q} + 7'h01) >= np)
          begin
            st_q <= ST_DRAIN;
            drain_q <= 1'b0;
          end
        end
        ST_DRAIN:
        begin
          // Passes do not overlap, so the channel stays fixed to its output
          drain_q <= 1'b1;
          if (drain_q)
          begin
            st_q <= ST_LOAD;
            ch_q <= ch_q + 4'h1;
          end
        end
      endcase
    end
  end

  // Adder operands: low bytes before the first adder cycle, high after
  assign add_bus.a_byte = (tick_q < 3'(`MFE_ADD_CYC)) ? buf_lo[ra_new] : buf_hi[ra_new];
  assign add_bus.b_byte = (tick_q < 3'(`MFE_ADD_CYC)) ? buf_lo[ra_old] : buf_hi[ra_old];
  assign add_bus.en_lo = add_lo;
  assign add_bus.en_hi = mac_en;

  mfe_pair_adder u_add (
    .clk(clk),
    .resetn(resetn),
    .bus(add_bus)
  );

  // Coefficient address runs two multiplier cycles behind the issue
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ca_d0_q <= 11'h000;
      ca_d1_q <= 11'h000;
    end
    else if (mac_en)
    begin
      ca_d0_q <= {set_q[ch_q], kk_q};
      ca_d1_q <= ca_d0_q;
    end
  end
  assign coef = $signed({cs_hi[ca_d1_q], cs_lo[ca_d1_q]});

  // Pipe flags follow each pair through adder and multiplier input
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      vld_q <= 3'h0;
      first_q <= 2'h0;
      last_q_p <= 2'h0;
      x_q <= 17'h00000;
    end
    else if (mac_en)
    begin
      vld_q <= {vld_q[1:0], iss};
      first_q <= {first_q[0], iss && kk_q == 6'h00};
      last_q_p <= {last_q_p[0], iss && 7'({1'b0, kk_q} + 7'h01) >= np};
      x_q <= add_bus.sum;
    end
  end

  // First product loads, later ones add; guard bits absorb growth
  always_comb
  begin
    prod = x_q * coef;
    acc_d = (first_q[1] ? 40'sh0000000000 : acc_q) + `MFE_ACC_W'(prod);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      acc_q <= 40'sh0000000000;
    else if (mac_en && vld_q[1])
      acc_q <= acc_d;
  end

  // Output only after the last accumulation of the pass
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_valid_q <= 1'b0;
      out_chan_q <= 4'h0;
      out_data_q <= 16'h0000;
    end
    else
    begin
      out_valid_q <= mac_en && vld_q[1] && last_q_p[1];
      if (mac_en && vld_q[1] && last_q_p[1])
      begin
        out_chan_q <= ch_q;
        out_data_q <= acc_d[`MFE_OUT_LSB+15:`MFE_OUT_LSB];
      end
    end
  end

  // Kept outputs for cascading, and the band-pass output count
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < `MFE_NCHAN; i++)
        last_q[i] <= 16'h0000;
      outs_q <= 5'h00;
    end
    else if (out_valid_q)
    begin
      last_q[out_chan_q] <= out_data_q;
      outs_q <= (outs_q == 5'(`MFE_BP_OUTS - 1)) ? 5'h00 : outs_q + 5'h01;
    end
  end

  assign out_valid = out_valid_q;
  assign out_chan = out_chan_q;
  assign out_data = out_data_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_last_issue;
    mac_en && iss && 7'({1'b0, kk_q} + 7'h01) >= np;
  endsequence

  a_mac_period: assert property (mac_en |=> !mac_en [*5] ##1 mac_en)
    else $error("multiplier cycle is not six clocks");
  a_adder_rate: assert property (add_lo |=> !mac_en [*2] ##1 mac_en)
    else $error("adder not at twice the multiplier rate");
  a_coef_step: assert property (mac_en && iss ##1 iss |->
    kk_q[1:0] == 2'($past(kk_q[1:0]) + 2'h1))
    else $error("coefficient index did not step");
  a_coef_delay: assert property (mac_en && iss |-> ##7 ca_d1_q[5:0] == $past(kk_q, 7))
    else $error("coefficient address not two cycles late");
  a_acc_first: assert property (mac_en && vld_q[1] && first_q[1] |=>
    acc_q == `MFE_ACC_W'($past(prod)))
    else $error("accumulator not loaded with first product");
  a_out_after_last: assert property (s_last_issue |-> ##13 out_valid_q)
    else $error("output not after last accumulation");
  a_lp_write: assert property (mac_en && st_q == ST_LOAD && act && mode == MFE_LOWPASS |=>
    wptr_q[ch_q] == 7'($past(wptr_q[ch_q]) + 7'h01))
    else $error("low-pass pointer not advanced");
  a_bp_hold: assert property (mac_en && mode == MFE_BANDPASS && outs_q != 5'h00 |=>
    $stable(wptr_q[0]))
    else $error("band-pass write before twenty outputs");
  a_bp_pairs: assert property (iss && mode == MFE_BANDPASS |-> kk_q < 6'(`MFE_BP_MAX_PAIRS))
    else $error("band-pass filter too long");
  a_addr_wrap: assert property (iss |-> ra_new[10:7] == ra_old[10:7] &&
    7'(ra_new[6:0] - ra_old[6:0]) == 7'({np, 1'b0} - {kk_q, 1'b0} - 8'h01))
    else $error("pair address left its region");
endmodule
`default_nettype wire

// File: verif/mfe_stream_partner.sv
// Sample source, coefficient loader and output collector facing the FIR engine
`timescale 1ns/1ps
`default_nettype none
module mfe_stream_partner (
  input wire logic clk, // Core clock
  output logic in_we, // Sample strobe
  output logic [3:0] in_chan, // Sample channel
  output logic [15:0] in_data, // Sample word
  output logic coef_we, // Coefficient strobe
  output logic [10:0] coef_addr, // Set and pair index
  output logic [15:0] coef_data, // Q15 coefficient
  input wire logic out_valid, // Output pulse
  input wire logic [3:0] out_chan, // Output channel
  input wire logic [15:0] out_data // Output word
);
  int cyc = 0; // Free clock count, used to time output spacing

  // Idle values from time zero
  initial
  begin
    in_we = 1'b0;
    in_chan = 4'h0;
    in_data = 16'h0000;
    coef_we = 1'b0;
    coef_addr = 11'h000;
    coef_data = 16'h0000;
  end

  // Clock counter
  always @(posedge clk)
    cyc <= cyc + 1;

  // One sample; afterwards the data lines show the inverse, never the old word
  task automatic send(input logic [3:0] ch, input logic [15:0] d);
    @(negedge clk);
    in_we = 1'b1;
    in_chan = ch;
    in_data = d;
    @(negedge clk);
    in_we = 1'b0;
    in_data = ~d;
  endtask

  // One coefficient word in fractional two's complement form
  task automatic load_coef(input logic [4:0] set, input logic [5:0] k, input logic [15:0] c);
    @(negedge clk);
    coef_we = 1'b1;
    coef_addr = {set, k};
    coef_data = c;
    @(negedge clk);
    coef_we = 1'b0;
    coef_data = ~c;
  endtask

  // Wait, bounded, for the next output of one channel
  task automatic get_out(input logic [3:0] ch, output logic [15:0] d, output int t,
                         output logic ok);
    int n;
    ok = 1'b0;
    d = 16'h0000;
    t = 0;
    for (n = 0; n < 4000 && !ok; n++)
    begin
      @(posedge clk);
      #1;
      if (out_valid === 1'b1 && out_chan === ch)
      begin
        ok = 1'b1;
        d = out_data;
        t = cyc;
      end
    end
  endtask
endmodule
`default_nettype wire

// File: verif/multichannel_fir_filter_engine_tb_top.sv
// Self-checking testbench of the multichannel FIR engine
`timescale 1ns/1ps
`default_nettype none
module multichannel_fir_filter_engine_tb_top
  import mfe_pkg::*;
();
  logic clk; // Core clock
  logic resetn; // Reset, active low
  mfe_mode_t mode; // Filter mode
  logic cfg_we, cfg_fb; // Setup strobe and feedback select
  logic [3:0] cfg_chan, cfg_src; // Setup channel and feedback source
  logic [4:0] cfg_set; // Coefficient set
  logic [6:0] cfg_pairs; // Pair count
  logic in_we, coef_we, out_valid; // Partner strobes and output pulse
  logic [3:0] in_chan, out_chan; // Channels
  logic [15:0] in_data, coef_data, out_data; // Data words
  logic [10:0] coef_addr; // Coefficient address
  int fails = 0; // Mismatch count
  int total_checks = 0; // Comparison count

  mfe_engine dut (.clk(clk), .resetn(resetn), .mode(mode), .in_we(in_we), .in_chan(in_chan),
    .in_data(in_data), .cfg_we(cfg_we), .cfg_chan(cfg_chan), .cfg_set(cfg_set),
    .cfg_pairs(cfg_pairs), .cfg_fb(cfg_fb), .cfg_src(cfg_src), .coef_we(coef_we),
    .coef_addr(coef_addr), .coef_data(coef_data), .out_valid(out_valid),
    .out_chan(out_chan), .out_data(out_data));
  mfe_stream_partner p (.clk(clk), .in_we(in_we), .in_chan(in_chan), .in_data(in_data),
    .coef_we(coef_we), .coef_addr(coef_addr), .coef_data(coef_data),
    .out_valid(out_valid), .out_chan(out_chan), .out_data(out_data));

  // 125 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Compare and count
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Next output of a channel; a missing pulse counts as a mismatch
  task automatic next(input logic [3:0] ch, output logic [15:0] d, output int t);
    logic ok;
    p.get_out(ch, d, t, ok);
    check("out_valid pulse", {15'h0000, ok}, 16'h0001);
  endtask

  // Channel setup write
  task automatic cfg(input logic [3:0] ch, input logic [4:0] set, input logic [6:0] np,
                     input logic fb, input logic [3:0] src);
    @(negedge clk);
    cfg_we = 1'b1;
    cfg_chan = ch;
    cfg_set = set;
    cfg_pairs = np;
    cfg_fb = fb;
    cfg_src = src;
    @(negedge clk);
    cfg_we = 1'b0;
  endtask

  // Skip every channel, then run channel 0 alone with one pair of set 0
  task automatic solo();
    for (int c = 0; c < 16; c++)
      cfg(c[3:0], 5'h00, 7'h00, 1'b0, 4'h0);
    cfg(4'h0, 5'h00, 7'h01, 1'b0, 4'h0);
  endtask

  // Floor of the mean of two samples, the one-pair result at coefficient one half
  function automatic logic [15:0] half(input logic [15:0] a, input logic [15:0] b);
    logic signed [16:0] s;
    s = $signed({a[15], a}) + $signed({b[15], b});
    return s[16:1];
  endfunction

  task automatic t_reset();
    check("out_valid", {15'h0000, out_valid}, 16'h0000);
    check("out_chan", {12'h000, out_chan}, 16'h0000);
    check("out_data", out_data, 16'h0000);
    $display("test reset done");
  endtask

  // One new sample per output; byte carries in both signs
  task automatic t_lowpass();
    logic [15:0] v[5] = '{16'h00C0, 16'hFF40, 16'h7FFF, 16'h8000, 16'h0181};
    logic [15:0] d;
    int t0, t1;
    p.load_coef(5'h00, 6'h00, 16'h4000);
    solo();
    mode = MFE_LOWPASS;
    p.send(4'h0, v[0]);
    repeat (3) next(4'h0, d, t0);
    check("settled", d, v[0]);
    for (int i = 1; i < 5; i++)
    begin
      p.send(4'h0, v[i]);
      next(4'h0, d, t0);
      check("mixed pair", d, half(v[i], v[i - 1]));
      next(4'h0, d, t1);
      check("new pair", d, v[i]);
    end
    check("period one pair", 16'(t1 - t0), 16'd114);
    $display("test lowpass done");
  endtask

  // Three pairs of distinct coefficients; spacing grows six clocks per pair
  task automatic t_pairs();
    logic [15:0] d;
    int t0, t1;
    p.load_coef(5'h02, 6'h00, 16'h1000);
    p.load_coef(5'h02, 6'h01, 16'h0800);
    p.load_coef(5'h02, 6'h02, 16'h0400);
    cfg(4'h0, 5'h02, 7'h03, 1'b0, 4'h0);
    p.send(4'h0, 16'h2000);
    repeat (8) next(4'h0, d, t0);
    next(4'h0, d, t1);
    check("three pair sum", d, 16'h0E00);
    check("period three pairs", 16'(t1 - t0), 16'd126);
    $display("test pairs done");
  endtask

  // Feedback from channel 0 into 1, and set 5 on the last channel
  task automatic t_multi();
    logic [15:0] d;
    int t;
    p.load_coef(5'h01, 6'h00, 16'h4000);
    p.load_coef(5'h05, 6'h00, 16'h2000);
    solo();
    cfg(4'h1, 5'h01, 7'h01, 1'b1, 4'h0);
    cfg(4'hF, 5'h05, 7'h01, 1'b0, 4'h0);
    p.send(4'h0, 16'h1234);
    p.send(4'h1, 16'h5555);
    p.send(4'hF, 16'h1000);
    repeat (4) next(4'h1, d, t);
    check("fed back channel", d, 16'h1234);
    next(4'hF, d, t);
    check("set five channel", d, 16'h0800);
    $display("test multi done");
  endtask

  // Band-pass bank: one sample written per twenty outputs
  task automatic t_bandpass();
    logic [15:0] d;
    int t, n, k;
    solo();
    mode = MFE_BANDPASS;
    p.send(4'h0, 16'h0100);
    d = 16'h0000;
    for (n = 0; n < 60 && d !== 16'h0100; n++)
      next(4'h0, d, t);
    p.send(4'h0, 16'h0300);
    for (n = 0; n < 25 && d === 16'h0100; n++)
      next(4'h0, d, t);
    check("first mixed output", d, 16'h0200);
    for (k = 0; k < 25 && d === 16'h0200; k++)
      next(4'h0, d, t);
    check("outputs per write", 16'(k), 16'd20);
    check("after next write", d, 16'h0300);
    // Forty pairs asked for; the bank runs sixteen, so a round is 34 multiplier cycles
    cfg(4'h0, 5'h00, 7'h28, 1'b0, 4'h0);
    repeat (2) next(4'h0, d, t);
    next(4'h0, d, k);
    check("band-pass clamp period", 16'(k - t), 16'd204);
    $display("test bandpass done");
  endtask

  // Counts and verdict
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog, well beyond the roughly 12000 clocks the tests need
  initial
  begin
    repeat (40000) @(posedge clk);
    fails++;
    $display("watchdog expired");
    end_sim();
  end

  // Main sequence
  initial
  begin
    resetn = 1'b0;
    mode = MFE_LOWPASS;
    cfg_we = 1'b0;
    cfg_fb = 1'b0;
    cfg_chan = 4'h0;
    cfg_src = 4'h0;
    cfg_set = 5'h00;
    cfg_pairs = 7'h00;
    repeat (3) @(posedge clk);
    @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    t_reset();
    t_lowpass();
    t_pairs();
    t_multi();
    t_bandpass();
    end_sim();
  end
endmodule
`default_nettype wire
